// ---- shared/dsmp_pkg.sv ----
// constants and register map of the drive start and manual preset block
package dsmp_pkg;
  // reference width and type shared by limits and manual reference
  localparam int REF_W = 16;
  typedef logic [REF_W-1:0] dsmp_ref_t;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MIN_SPEED = 8'h04;
  localparam logic [7:0] ADDR_MAX_SPEED = 8'h08;
  localparam logic [7:0] ADDR_MAN_REF = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // control register fields
  localparam int CTRL_PRESET_BIT = 0;
  localparam int CTRL_LEVEL_BIT = 1;
  localparam int CTRL_FLRESP_BIT = 2;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_SRC_MSB = 5;

  // status register fields
  localparam int ST_RUN_BIT = 0;
  localparam int ST_FORCED_BIT = 1;
  localparam int ST_LOCAL_BIT = 2;
  localparam int ST_MANUAL_BIT = 3;
  localparam int ST_FLFAULT_BIT = 4;

  // control source selector codes
  localparam logic [1:0] SRC_FRONT_PANEL = 2'h0;
  localparam logic [1:0] SRC_TERMINAL_STRIP = 2'h1;
  localparam logic [1:0] SRC_OPTION_PORT = 2'h2;
  localparam logic [1:0] SRC_SERIAL_PORT = 2'h3;

  // function loss response that coasts without a fault
  localparam logic FL_RESP_NO_FAULT = 1'b1;

  // values after reset
  localparam logic RST_PRESET_EN = 1'b0;
  localparam logic RST_LEVEL_EN = 1'b0;
  localparam logic RST_FL_RESP = 1'b0;
  localparam logic [1:0] RST_SRC = SRC_FRONT_PANEL;
  localparam dsmp_ref_t RST_MIN_SPEED = 16'h0000;
  localparam dsmp_ref_t RST_MAX_SPEED = 16'hFFFF;
  localparam dsmp_ref_t RST_MAN_REF = 16'h0000;

  // cycles after reset before pin levels are trusted
  localparam logic [1:0] PRIME_CYCLES = 2'h3;

  // bit positions of the synchronised pin bundle
  localparam int IN_START = 0;
  localparam int IN_STOP = 1;
  localparam int IN_FNLOSS = 2;
  localparam int IN_REMLOC = 3;
  localparam int IN_AUTOMAN = 4;
  localparam int IN_STOPKEY = 5;
  localparam int IN_EDIT = 6;
  localparam int IN_COUNT = 7;
endpackage

// ---- src/dsmp_start_ctrl.sv ----
// run permission, start detection and manual reference preset logic
// Behaviour
// - preset enabled loads manual from auto
// - preset disabled leaves manual reference unchanged
// - preset uses magnitude of auto reference
// - preset value clamped between speed limits
// - keypad editing skips the preset
// - level enable selects edge or level start
// - front panel, serial start on edge only
// - start needs fnloss, no fault, bus, no stop
// - edge mode runs after start rising edge
// - level mode runs while start asserted
// - fault coasts; level mode restarts after fault clears
// - fnloss response one coasts without fault
// - stop key forces a fresh start edge
// - self-tune completion forces fresh start edge
// - source change cancels force, acts as edge
// - switch toggle acts like source change
// - switch state at power-up picks local
// - four source values steer start behaviour
// - terminal strip with switch closed is local
`timescale 1ns/1ps
module dsmp_start_ctrl (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic startIn,
  input wire logic stopIn,
  input wire logic fnLossIn,
  input wire logic remoteLocalSwitch,
  input wire logic autoManualSelect,
  input wire logic stopKeyIn,
  input wire logic keypadEditIn,
  input wire logic faultActive,
  input wire logic dcBusValid,
  input wire logic selfTuneDone,
  input wire dsmp_pkg::dsmp_ref_t autoRef,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  output logic powerOn,
  output dsmp_pkg::dsmp_ref_t manualRef,
  output logic manualMode,
  output logic localActive,
  output logic forcedEdgePending,
  output logic fnLossFault
);
  typedef struct packed {
    logic [1:0] primeCnt;
    logic primed, swPrev, startPrev, manPrev, stopKeyPrev;
    logic [1:0] effSrcPrev;
    logic forced, run, isLocal, flFault;
    logic presetEn, levelEn, flResp;
    logic [1:0] srcSel;
    dsmp_pkg::dsmp_ref_t minSpd, maxSpd, manRef;
    logic [31:0] rdData;
  } dsmp_state_s;

  dsmp_state_s st_reg;
  dsmp_state_s st_next;

  logic [dsmp_pkg::IN_COUNT-1:0] pinBus;
  logic [dsmp_pkg::IN_COUNT-1:0] syncBus;
  logic sStart, sStop, sFnLoss, sSw, sMan, sKey, sEdit;
  logic [1:0] effSrc;
  logic stripOpt, startEdge, stopKeyRise, manRise, srcChanged, permit;
  logic levelMode, startTrig, presetTake, manRefWr;
  dsmp_pkg::dsmp_ref_t presetVal, wrRef;

  ////////////////////////////////////////////////////////////////////////////
  // every contact and keypad pin passes two flip-flops before anything reads it; fault, bus and tune lines are read directly
  assign pinBus = {keypadEditIn, stopKeyIn, autoManualSelect,
                   remoteLocalSwitch, fnLossIn, stopIn, startIn};
  dsmp_sync_bank #(.WIDTH(dsmp_pkg::IN_COUNT)) u_sync (
    .sys_clk(sys_clk), .reset(reset), .pinIn(pinBus), .syncOut(syncBus)
  );

  assign sStart = syncBus[dsmp_pkg::IN_START];
  assign sStop = syncBus[dsmp_pkg::IN_STOP];
  assign sFnLoss = syncBus[dsmp_pkg::IN_FNLOSS];
  assign sSw = syncBus[dsmp_pkg::IN_REMLOC];
  assign sMan = syncBus[dsmp_pkg::IN_AUTOMAN];
  assign sKey = syncBus[dsmp_pkg::IN_STOPKEY];
  assign sEdit = syncBus[dsmp_pkg::IN_EDIT];

  ////////////////////////////////////////////////////////////////////////////
  // magnitude of the auto reference, limited to the speed window
  function automatic dsmp_pkg::dsmp_ref_t clampRef(
    input dsmp_pkg::dsmp_ref_t ref_in,
    input dsmp_pkg::dsmp_ref_t lo,
    input dsmp_pkg::dsmp_ref_t hi
  );
    logic [dsmp_pkg::REF_W:0] mag;
    // 17 bits so the most negative value has a true magnitude
    mag = ref_in[dsmp_pkg::REF_W-1] ?
          ((dsmp_pkg::REF_W+1)'(0) - {1'b1, ref_in}) :
          {1'b0, ref_in};
    clampRef = (mag < {1'b0, lo}) ? lo :
               (mag > {1'b0, hi}) ? hi : mag[dsmp_pkg::REF_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // effective source: terminal strip with switch closed behaves as local
  assign effSrc = (st_reg.srcSel == dsmp_pkg::SRC_TERMINAL_STRIP && sSw) ?
                  dsmp_pkg::SRC_FRONT_PANEL : st_reg.srcSel;
  assign stripOpt = (effSrc == dsmp_pkg::SRC_TERMINAL_STRIP) ||
                    (effSrc == dsmp_pkg::SRC_OPTION_PORT);

  // edges compare synced level with last sample; gated until primed
  assign startEdge = st_reg.primed && sStart && !st_reg.startPrev;
  assign stopKeyRise = st_reg.primed && sKey && !st_reg.stopKeyPrev;
  assign manRise = st_reg.primed && sMan && !st_reg.manPrev;
  // a switch toggle counts as a source change even with no selector write
  assign srcChanged = st_reg.primed &&
                      ((effSrc != st_reg.effSrcPrev) ||
                       (sSw != st_reg.swPrev));
  // permissives hold in both start modes
  assign permit = sFnLoss && !faultActive && dcBusValid && !sStop;
  // level sensing only for terminal strip and option port
  assign levelMode = st_reg.levelEn && stripOpt;
  // return to strip or option acts as a start edge
  assign startTrig = startEdge ||
                     (levelMode && sStart && !st_reg.forced) ||
                     (srcChanged && stripOpt && sStart);
  // preset request, its clamped value and the write path
  assign presetTake = manRise && st_reg.presetEn && !sEdit;
  assign presetVal = clampRef(autoRef, st_reg.minSpd, st_reg.maxSpd);
  assign manRefWr = regWrEn && (regAddr == dsmp_pkg::ADDR_MAN_REF);
  assign wrRef = regWrData[dsmp_pkg::REF_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    st_next = st_reg;
    st_next.rdData = 32'h0000_0000;
    st_next.startPrev = sStart;
    st_next.manPrev = sMan;
    st_next.stopKeyPrev = sKey;
    st_next.swPrev = sSw;
    st_next.effSrcPrev = effSrc;
    st_next.isLocal = (effSrc == dsmp_pkg::SRC_FRONT_PANEL) &&
                      (st_reg.srcSel == dsmp_pkg::SRC_TERMINAL_STRIP);

    // wait for the synchroniser to fill; switch level then taken as is
    if (!st_reg.primed) begin
      st_next.primeCnt = st_reg.primeCnt + 2'h1;
      if (st_reg.primeCnt == dsmp_pkg::PRIME_CYCLES) begin
        st_next.primed = 1'b1;
      end
    end

    // run flag: any lost permissive coasts at once
    if (!st_reg.primed || !permit) begin
      st_next.run = 1'b0;
    end else if (stopKeyRise) begin
      st_next.run = 1'b0;
    end else if (st_reg.run) begin
      if (levelMode && !sStart) begin
        st_next.run = 1'b0;
      end
    end else if (startTrig) begin
      st_next.run = 1'b1;
    end

    // sticky force flag; set beats a same-cycle clear
    if ((stopKeyRise || (selfTuneDone && st_reg.primed)) && stripOpt) begin
      st_next.forced = 1'b1;
    end else if (startEdge || srcChanged) begin
      st_next.forced = 1'b0;
    end

    // function loss with fault response raises a sticky fault flag
    if (st_reg.run && !sFnLoss &&
        st_reg.flResp != dsmp_pkg::FL_RESP_NO_FAULT) begin
      st_next.flFault = 1'b1;
    end else if (regWrEn && regAddr == dsmp_pkg::ADDR_STATUS &&
                 regWrData[dsmp_pkg::ST_FLFAULT_BIT]) begin
      st_next.flFault = 1'b0;
    end

    // register writes
    if (regWrEn) begin
      unique case (regAddr)
        dsmp_pkg::ADDR_CTRL: begin
          st_next.presetEn = regWrData[dsmp_pkg::CTRL_PRESET_BIT];
          st_next.levelEn = regWrData[dsmp_pkg::CTRL_LEVEL_BIT];
          st_next.flResp = regWrData[dsmp_pkg::CTRL_FLRESP_BIT];
          st_next.srcSel =
            regWrData[dsmp_pkg::CTRL_SRC_MSB:dsmp_pkg::CTRL_SRC_LSB];
        end
        dsmp_pkg::ADDR_MIN_SPEED: st_next.minSpd = wrRef;
        dsmp_pkg::ADDR_MAX_SPEED: st_next.maxSpd = wrRef;
        dsmp_pkg::ADDR_MAN_REF: st_next.manRef = wrRef;
        default: ;
      endcase
    end

    // preset beats a same-cycle software write of the manual reference
    if (presetTake) begin
      st_next.manRef = presetVal;
    end

    // read data stand one cycle after the strobe, zero otherwise
    if (regRdEn) begin
      unique case (regAddr)
        dsmp_pkg::ADDR_CTRL: begin
          st_next.rdData[dsmp_pkg::CTRL_PRESET_BIT] = st_reg.presetEn;
          st_next.rdData[dsmp_pkg::CTRL_LEVEL_BIT] = st_reg.levelEn;
          st_next.rdData[dsmp_pkg::CTRL_FLRESP_BIT] = st_reg.flResp;
          st_next.rdData[dsmp_pkg::CTRL_SRC_MSB:dsmp_pkg::CTRL_SRC_LSB] =
            st_reg.srcSel;
        end
        dsmp_pkg::ADDR_MIN_SPEED: begin
          st_next.rdData[dsmp_pkg::REF_W-1:0] = st_reg.minSpd;
        end
        dsmp_pkg::ADDR_MAX_SPEED: begin
          st_next.rdData[dsmp_pkg::REF_W-1:0] = st_reg.maxSpd;
        end
        dsmp_pkg::ADDR_MAN_REF: begin
          st_next.rdData[dsmp_pkg::REF_W-1:0] = st_reg.manRef;
        end
        dsmp_pkg::ADDR_STATUS: begin
          st_next.rdData[dsmp_pkg::ST_RUN_BIT] = st_reg.run;
          st_next.rdData[dsmp_pkg::ST_FORCED_BIT] = st_reg.forced;
          st_next.rdData[dsmp_pkg::ST_LOCAL_BIT] = st_reg.isLocal;
          st_next.rdData[dsmp_pkg::ST_MANUAL_BIT] = st_reg.manPrev;
          st_next.rdData[dsmp_pkg::ST_FLFAULT_BIT] = st_reg.flFault;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register with constant reset values
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.presetEn <= dsmp_pkg::RST_PRESET_EN;
      st_reg.levelEn <= dsmp_pkg::RST_LEVEL_EN;
      st_reg.flResp <= dsmp_pkg::RST_FL_RESP;
      st_reg.srcSel <= dsmp_pkg::RST_SRC;
      st_reg.effSrcPrev <= dsmp_pkg::RST_SRC;
      st_reg.minSpd <= dsmp_pkg::RST_MIN_SPEED;
      st_reg.maxSpd <= dsmp_pkg::RST_MAX_SPEED;
      st_reg.manRef <= dsmp_pkg::RST_MAN_REF;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state flip-flops
  assign regRdData = st_reg.rdData;
  assign powerOn = st_reg.run;
  assign manualRef = st_reg.manRef;
  assign manualMode = st_reg.manPrev;
  assign localActive = st_reg.isLocal;
  assign forcedEdgePending = st_reg.forced;
  assign fnLossFault = st_reg.flFault;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the driven behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_noPermit;
    !permit |=> !powerOn;
  endproperty
  a_noPermit: assert property (p_noPermit)
    else $error("ran without all permissives");
  property p_presetLoad;
    presetTake |=> manualRef == $past(presetVal);
  endproperty
  a_presetLoad: assert property (p_presetLoad)
    else $error("manual reference not preset");
  property p_presetOff;
    manRise && !st_reg.presetEn && !manRefWr |=> $stable(manualRef);
  endproperty
  a_presetOff: assert property (p_presetOff)
    else $error("manual reference changed with preset off");
  property p_presetWindow;
    presetTake && st_reg.minSpd <= st_reg.maxSpd |=>
      manualRef >= $past(st_reg.minSpd) && manualRef <= $past(st_reg.maxSpd);
  endproperty
  a_presetWindow: assert property (p_presetWindow)
    else $error("preset outside speed window");
  property p_presetPositive;
    presetTake && autoRef[dsmp_pkg::REF_W-1] && st_reg.minSpd == 16'h0000 &&
      st_reg.maxSpd == 16'hFFFF |=>
      manualRef == dsmp_pkg::dsmp_ref_t'(16'h0000 - $past(autoRef));
  endproperty
  a_presetPositive: assert property (p_presetPositive)
    else $error("negative auto reference not made positive");
  property p_editSkip;
    manRise && sEdit && !manRefWr |=> $stable(manualRef);
  endproperty
  a_editSkip: assert property (p_editSkip)
    else $error("preset taken while keypad edits");
  property p_edgeOnly;
    !powerOn && !levelMode && !startEdge && !srcChanged |=> !powerOn;
  endproperty
  a_edgeOnly: assert property (p_edgeOnly)
    else $error("edge mode started without an edge");
  property p_levelRun;
    st_reg.primed && permit && levelMode && sStart && !st_reg.forced &&
      !stopKeyRise |=> powerOn;
  endproperty
  a_levelRun: assert property (p_levelRun)
    else $error("level mode did not start");
  property p_stopKeyForce;
    stopKeyRise && stripOpt |=> forcedEdgePending && !powerOn;
  endproperty
  a_stopKeyForce: assert property (p_stopKeyForce)
    else $error("stop key did not force a fresh edge");
  property p_tuneForce;
    selfTuneDone && st_reg.primed && stripOpt |=> forcedEdgePending;
  endproperty
  a_tuneForce: assert property (p_tuneForce)
    else $error("self-tune did not force a fresh edge");
  property p_srcClear;
    srcChanged && !stopKeyRise && !selfTuneDone |=> !forcedEdgePending;
  endproperty
  a_srcClear: assert property (p_srcClear)
    else $error("source change left the force flag set");
  property p_localStrip;
    st_reg.srcSel == dsmp_pkg::SRC_TERMINAL_STRIP && sSw |=> localActive;
  endproperty
  a_localStrip: assert property (p_localStrip)
    else $error("closed switch on strip source not local");
  c_levelStart: cover property (levelMode && !powerOn ##1 powerOn);
  c_preset: cover property (presetTake);
  c_srcReturn: cover property (srcChanged && stripOpt && sStart ##1 powerOn);
  c_stopKey: cover property (powerOn && stopKeyRise);
endmodule

// ---- src/dsmp_sync_bank.sv ----
// two flip-flop synchroniser bank for asynchronous pin levels
`timescale 1ns/1ps
module dsmp_sync_bank #(
  parameter int WIDTH = 7
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dsmp_sync_s;

  dsmp_sync_s st_reg;
  dsmp_sync_s st_next;

  ////////////////////////////////////////////////////////////////////////////
  // stage1 feeds only stage2, so metastability never reaches logic
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = pinIn;
    st_next.stage2 = st_reg.stage1;
  end

  // all stages clear to zero under reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign syncOut = st_reg.stage2;
endmodule

// ---- tb/dsmp_far_side.sv ----
// far-side model: terminal strip contacts, keypads and drive status lines
`timescale 1ns/1ps
module dsmp_far_side (
  input wire logic sys_clk,
  output logic startIn,
  output logic stopIn,
  output logic fnLossIn,
  output logic remoteLocalSwitch,
  output logic autoManualSelect,
  output logic stopKeyIn,
  output logic keypadEditIn,
  output logic faultActive,
  output logic dcBusValid,
  output logic selfTuneDone,
  output dsmp_pkg::dsmp_ref_t autoRef
);
  logic [6:0] lv;
  // contact bank levels, indexed like the synchronised pin bundle
  assign startIn = lv[dsmp_pkg::IN_START];
  assign stopIn = lv[dsmp_pkg::IN_STOP];
  assign fnLossIn = lv[dsmp_pkg::IN_FNLOSS];
  assign remoteLocalSwitch = lv[dsmp_pkg::IN_REMLOC];
  assign autoManualSelect = lv[dsmp_pkg::IN_AUTOMAN];
  assign stopKeyIn = lv[dsmp_pkg::IN_STOPKEY];
  assign keypadEditIn = lv[dsmp_pkg::IN_EDIT];
  // healthy drive at power-up: function loss closed, bus valid
  initial begin
    lv = 7'h04;
    faultActive = 1'b0;
    dcBusValid = 1'b1;
    selfTuneDone = 1'b0;
    autoRef = 16'h0000;
  end
  // levels move just after an edge, like a contact read by a scan
  task automatic pin(input int idx, input logic v);
    @(posedge sys_clk);
    lv[idx] <= v;
  endtask
  task automatic stat(input logic f, input logic b);
    @(posedge sys_clk);
    faultActive <= f;
    dcBusValid <= b;
  endtask
  // completion of self-tuning is a single-cycle pulse
  task automatic tune();
    @(posedge sys_clk);
    selfTuneDone <= 1'b1;
    @(posedge sys_clk);
    selfTuneDone <= 1'b0;
  endtask
  task automatic aref(input dsmp_pkg::dsmp_ref_t v);
    @(posedge sys_clk);
    autoRef <= v;
  endtask
endmodule

// ---- tb/dsmp_start_ctrl_bench.sv ----
// self-checking bench for the start control and manual preset block
`timescale 1ns/1ps
module dsmp_start_ctrl_bench;
  logic sys_clk, reset, startIn, stopIn, fnLossIn, remoteLocalSwitch;
  logic autoManualSelect, stopKeyIn, keypadEditIn, faultActive;
  logic dcBusValid, selfTuneDone, regWrEn, regRdEn, powerOn;
  logic manualMode, localActive, forcedEdgePending, fnLossFault;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData;
  dsmp_pkg::dsmp_ref_t autoRef, manualRef;
  int numErrors, samplesChecked, a, lo, hi, e;
  int expQ[$];
  logic pe, ed;

  dsmp_start_ctrl dut (.sys_clk(sys_clk), .reset(reset),
    .startIn(startIn), .stopIn(stopIn), .fnLossIn(fnLossIn),
    .remoteLocalSwitch(remoteLocalSwitch),
    .autoManualSelect(autoManualSelect), .stopKeyIn(stopKeyIn),
    .keypadEditIn(keypadEditIn), .faultActive(faultActive),
    .dcBusValid(dcBusValid), .selfTuneDone(selfTuneDone),
    .autoRef(autoRef), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .powerOn(powerOn), .manualRef(manualRef), .manualMode(manualMode),
    .localActive(localActive), .forcedEdgePending(forcedEdgePending),
    .fnLossFault(fnLossFault));
  dsmp_far_side fs (.sys_clk(sys_clk), .startIn(startIn),
    .stopIn(stopIn), .fnLossIn(fnLossIn),
    .remoteLocalSwitch(remoteLocalSwitch),
    .autoManualSelect(autoManualSelect), .stopKeyIn(stopKeyIn),
    .keypadEditIn(keypadEditIn), .faultActive(faultActive),
    .dcBusValid(dcBusValid), .selfTuneDone(selfTuneDone),
    .autoRef(autoRef));

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // pin to output is three edges; one spare, then let updates land
  task automatic settle();
    tick(4);
    #1;
  endtask
  task automatic check(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
    samplesChecked++;
    if (g !== x) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic flag(input string nm, input logic x, input logic g);
    check(nm, {31'h0, x}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= ad;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdChk(input string nm, input logic [7:0] ad,
                       input logic [31:0] x);
    @(posedge sys_clk);
    regAddr <= ad;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1;
    check(nm, x, regRdData);
  endtask
  task automatic ctrl(input logic p, input logic l, input logic f,
                      input logic [1:0] s);
    wr(dsmp_pkg::ADDR_CTRL, {26'h0, s, 1'b0, f, l, p});
  endtask
  task automatic kick(input int idx);
    fs.pin(idx, 1'b1);
    fs.pin(idx, 1'b0);
  endtask
  // reference model: sign dropped, then clamped between the limits
  function automatic int presetVal(input int v, input int mn,
                                   input int mx);
    int m;
    m = (v >= 32768) ? 65536 - v : v;
    if (m < mn) m = mn;
    if (m > mx) m = mx;
    return m;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // guard against a hang anywhere in the sequence
  initial begin
    tick(60000);
    numErrors++;
    $display("mismatch watchdog expected done seen hung");
    results();
  end

  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    numErrors = 0;
    samplesChecked = 0;
    void'($urandom(5710));
    tick(12);
    reset <= 1'b0;
    tick(8);
    rdChk("ctrl", dsmp_pkg::ADDR_CTRL, 32'h0);
    rdChk("minSpeed", dsmp_pkg::ADDR_MIN_SPEED, 32'h0);
    rdChk("maxSpeed", dsmp_pkg::ADDR_MAX_SPEED, 32'h0000FFFF);
    rdChk("manRef", dsmp_pkg::ADDR_MAN_REF, 32'h0);
    wr(8'h14, 32'hFFFFFFFF);
    rdChk("unmapped", 8'h14, 32'h0);
    wr(dsmp_pkg::ADDR_STATUS, 32'h0000000F);
    rdChk("status", dsmp_pkg::ADDR_STATUS, 32'h0);
    $display("test registers done");
    // edge mode on the strip: a held start is not enough
    ctrl(1'b0, 1'b0, 1'b0, dsmp_pkg::SRC_TERMINAL_STRIP);
    settle();
    flag("localActive", 1'b0, localActive);
    fs.pin(dsmp_pkg::IN_STOP, 1'b1);
    fs.pin(dsmp_pkg::IN_START, 1'b1);
    fs.pin(dsmp_pkg::IN_STOP, 1'b0);
    settle();
    flag("powerOn", 1'b0, powerOn);
    fs.pin(dsmp_pkg::IN_START, 1'b0);
    fs.pin(dsmp_pkg::IN_START, 1'b1);
    settle();
    flag("powerOn", 1'b1, powerOn);
    fs.stat(1'b0, 1'b0);
    settle();
    flag("powerOn", 1'b0, powerOn);
    fs.stat(1'b0, 1'b1);
    settle();
    flag("powerOn", 1'b0, powerOn);
    $display("test edge start done");
    // level mode: faults and function loss
    ctrl(1'b0, 1'b1, 1'b0, dsmp_pkg::SRC_TERMINAL_STRIP);
    settle();
    flag("powerOn", 1'b1, powerOn);
    fs.stat(1'b1, 1'b1);
    settle();
    flag("powerOn", 1'b0, powerOn);
    fs.stat(1'b0, 1'b1);
    settle();
    flag("powerOn", 1'b1, powerOn);
    ctrl(1'b0, 1'b1, 1'b1, dsmp_pkg::SRC_TERMINAL_STRIP);
    fs.pin(dsmp_pkg::IN_FNLOSS, 1'b0);
    settle();
    flag("powerOn", 1'b0, powerOn);
    flag("fnLossFault", 1'b0, fnLossFault);
    fs.pin(dsmp_pkg::IN_FNLOSS, 1'b1);
    settle();
    flag("powerOn", 1'b1, powerOn);
    ctrl(1'b0, 1'b1, 1'b0, dsmp_pkg::SRC_TERMINAL_STRIP);
    fs.pin(dsmp_pkg::IN_FNLOSS, 1'b0);
    settle();
    flag("fnLossFault", 1'b1, fnLossFault);
    fs.pin(dsmp_pkg::IN_FNLOSS, 1'b1);
    wr(dsmp_pkg::ADDR_STATUS, 32'h00000010);
    settle();
    rdChk("status", dsmp_pkg::ADDR_STATUS, 32'h1);
    $display("test level start done");
    // stop key, source round trip and switch toggle
    kick(dsmp_pkg::IN_STOPKEY);
    settle();
    flag("powerOn", 1'b0, powerOn);
    flag("forced", 1'b1, forcedEdgePending);
    ctrl(1'b0, 1'b1, 1'b0, dsmp_pkg::SRC_FRONT_PANEL);
    ctrl(1'b0, 1'b1, 1'b0, dsmp_pkg::SRC_TERMINAL_STRIP);
    settle();
    flag("powerOn", 1'b1, powerOn);
    flag("forced", 1'b0, forcedEdgePending);
    kick(dsmp_pkg::IN_STOPKEY);
    fs.pin(dsmp_pkg::IN_REMLOC, 1'b1);
    settle();
    flag("localActive", 1'b1, localActive);
    flag("powerOn", 1'b0, powerOn);
    fs.pin(dsmp_pkg::IN_REMLOC, 1'b0);
    settle();
    flag("powerOn", 1'b1, powerOn);
    fs.tune();
    settle();
    flag("forced", 1'b1, forcedEdgePending);
    fs.pin(dsmp_pkg::IN_START, 1'b0);
    settle();
    flag("powerOn", 1'b0, powerOn);
    fs.pin(dsmp_pkg::IN_START, 1'b1);
    settle();
    flag("powerOn", 1'b1, powerOn);
    flag("forced", 1'b0, forcedEdgePending);
    $display("test forced edge done");
    // every source: level start only for strip and option port
    for (int s = 0; s < 4; s++) begin
      fs.pin(dsmp_pkg::IN_START, 1'b0);
      ctrl(1'b0, 1'b1, 1'b0, 2'(s));
      fs.pin(dsmp_pkg::IN_STOP, 1'b1);
      fs.pin(dsmp_pkg::IN_START, 1'b1);
      fs.pin(dsmp_pkg::IN_STOP, 1'b0);
      settle();
      flag("powerOn", s == 1 || s == 2, powerOn);
    end
    fs.pin(dsmp_pkg::IN_START, 1'b0);
    $display("test sources done");
    // auto to manual preset with corner and random references
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 32768 : (i == 1) ? 65535 : $urandom_range(65535);
      lo = (i == 0) ? 0 : $urandom_range(16384);
      hi = (i == 0) ? 65535 : lo + $urandom_range(32768);
      pe = (i != 2);
      ed = (i == 3);
      fs.pin(dsmp_pkg::IN_AUTOMAN, 1'b0);
      settle();
      ctrl(pe, 1'b0, 1'b0, dsmp_pkg::SRC_FRONT_PANEL);
      wr(dsmp_pkg::ADDR_MIN_SPEED, 32'(lo));
      wr(dsmp_pkg::ADDR_MAX_SPEED, 32'(hi));
      wr(dsmp_pkg::ADDR_MAN_REF, 32'h00001234);
      fs.aref(16'(a));
      fs.pin(dsmp_pkg::IN_EDIT, ed);
      fs.pin(dsmp_pkg::IN_AUTOMAN, 1'b1);
      expQ.push_back((pe && !ed) ? presetVal(a, lo, hi) : 32'h1234);
      settle();
      e = expQ.pop_front();
      check("manualRef", 32'(e), {16'h0, manualRef});
      flag("manualMode", 1'b1, manualMode);
      rdChk("manRef", dsmp_pkg::ADDR_MAN_REF, 32'(e));
      fs.pin(dsmp_pkg::IN_EDIT, 1'b0);
    end
    $display("test preset done");
    results();
  end
endmodule
